// ### design/gpvi_pkg.sv
// Purpose: Shared constants and types for the grouped priority vector interrupt block
// Assumes: 100 MHz reference clock, 24 source slots (slot 23 unused)
// Notes:   Vector addresses are 16-bit program addresses
package gpvi_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int unsigned NUM_SRC    = 24;
  localparam int unsigned NUM_GROUPS = 6;
  localparam int unsigned IDX_W      = 5;
  localparam int unsigned VEC_W      = 16;

  // ------------------------------------------------------------
  // Vectors, slots, reset values
  // ------------------------------------------------------------
  localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;
  localparam logic [VEC_W-1:0] VECTOR_BASE  = 16'h0003;
  localparam int unsigned      VECTOR_SHIFT = 3;
  localparam logic [IDX_W-1:0] LAST_SLOT    = 5'h16;
  localparam logic [IDX_W-1:0] CONVERTER_SLOT      = 5'h06;
  localparam logic [IDX_W-1:0] WATCHDOG_SLOT       = 5'h15;
  localparam logic [IDX_W-1:0] INTERVAL_TIMER_SLOT = 5'h16;
  localparam logic [5:0]       ENABLE_RESET   = 6'h00;
  localparam logic [5:0]       PRIORITY_RESET = 6'h00;
  localparam logic [4:0]       ENABLE_D_RESET = 5'h00;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [5:0] enable_reg_a;
    logic [5:0] enable_reg_b;
    logic [5:0] enable_reg_c;
    logic [4:0] enable_reg_d;
    logic [5:0] priority_low_bits;
    logic [5:0] priority_high_bits;
  } gpvi_cfg_s;

  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] source;
    logic [VEC_W-1:0] vector;
    logic [1:0]       level;
  } gpvi_req_s;

  typedef enum logic [1:0] {
    GPVI_IDLE,
    GPVI_OFFER
  } gpvi_state_e;

endpackage

// ### design/gpvi_controller.sv
// Purpose: Grouped priority vector interrupt controller for an 8-bit core
// Assumes: Sources are synchronous to ref_clk_in, the reset pin is not; CPU answers with a pulse
// Notes:   Resolution is fully combinational, the offer to the CPU is registered
`timescale 1ns/1ns

// What this block does
// - Six groups; group k holds sources k, k+6, k+12, k+18, but group 5 only 5, 11, 17; lowest source wins a level tie.
// - Group level is two bits, one from each priority register at the group position.
// - A higher-level pending request is offered before a lower-level one.
// - Ties broken by fixed source order; reset first, then lower source number wins.
// - CPU long-calls the vector of the winning source on accept.
// - Vectors: reset 0000H, source 0 at 0003H, then 8 bytes apart to 00B3H.
// - Reset is non-maskable; four enable registers gate sources 0 to 22.
// - Fixed slot assignment of pins, converter, line, timers, siren, serial, watchdog.
// - Global enable low blocks every maskable request; high defers to per-source enables.
// - Global enable clears on vector entry and sets again on return-from-irq.
// - Four levels with nesting; only a higher level preempts running service.
// - Request to vector entry latency lies within 3 to 9 machine cycles.
module gpvi_controller (
  input  wire logic                        ref_clk_in,
  input  wire logic                        reset_n_in,
  input  wire logic [gpvi_pkg::NUM_SRC-2:0] irq_request_in,
  input  wire logic                        hardware_reset_pin_in,
  input  wire gpvi_pkg::gpvi_cfg_s         cfg_in,
  input  wire logic                        global_irq_enable_set_in,
  input  wire logic                        global_irq_enable_clr_in,
  input  wire logic                        long_call_accept_in,
  input  wire logic                        return_from_irq_in,
  output logic                             irq_offer_out,
  output logic [gpvi_pkg::VEC_W-1:0]       irq_vector_out,
  output logic [gpvi_pkg::IDX_W-1:0]       irq_source_out,
  output logic [gpvi_pkg::NUM_SRC-2:0]     irq_ack_out,
  output logic                             global_irq_enable_out,
  output logic [1:0]                       active_level_out,
  output logic                             in_service_out
);
  import gpvi_pkg::*;

  // ------------------------------------------------------------
  // Masking and per-source level
  // ------------------------------------------------------------
  logic [NUM_SRC-2:0] src_enable;
  logic [NUM_SRC-2:0] src_live;
  logic [1:0]         src_level [NUM_SRC-1];
  logic               global_irq_enable;
  logic [3:0]         level_in_service;
  logic               reset_req_q;

  assign src_enable = {cfg_in.enable_reg_d, cfg_in.enable_reg_c,
                       cfg_in.enable_reg_b, cfg_in.enable_reg_a};

  genvar g;
  generate
    for (g = 0; g < NUM_SRC - 1; g++) begin : g_src
      // Group of slot g is g mod 6
      assign src_level[g] = {cfg_in.priority_high_bits[g % NUM_GROUPS],
                             cfg_in.priority_low_bits[g % NUM_GROUPS]};
      assign src_live[g] = irq_request_in[g] & src_enable[g] & global_irq_enable;
    end
  endgenerate

  // ------------------------------------------------------------
  // Winner selection
  // ------------------------------------------------------------
  // Scanning from the highest slot down lets the lowest number win on a tie
  logic             win_valid;
  logic [IDX_W-1:0] win_src;
  logic [1:0]       win_level;
  logic [1:0]       svc_top;

  always_comb begin
    svc_top = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (level_in_service[l]) begin
        svc_top = 2'(l);
      end
    end
  end

  always_comb begin
    win_valid = 1'b0;
    win_src   = '0;
    win_level = 2'h0;
    for (int s = NUM_SRC - 2; s >= 0; s--) begin
      if (src_live[s] && (!win_valid || src_level[s] >= win_level)) begin
        win_valid = 1'b1;
        win_src   = IDX_W'(s);
        win_level = src_level[s];
      end
    end
  end

  // Nesting: a request competes only above the highest level now in service
  logic win_allowed;
  assign win_allowed = win_valid &&
                       ((level_in_service == 4'h0) || (win_level > svc_top));

  // ------------------------------------------------------------
  // Hardware reset pin synchroniser and request capture
  // ------------------------------------------------------------
  // Three stages; a level counts once stages two and three agree, which drops glitches
  // Limitation: a pin pulse not high at two successive rising edges is never seen
  logic [2:0] hrst_sync;
  logic       hrst_seen;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hrst_sync <= 3'h0;
    end else begin
      hrst_sync <= {hrst_sync[1:0], hardware_reset_pin_in};
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hrst_seen <= 1'b0;
    end else if (hrst_sync[1] == hrst_sync[2]) begin
      hrst_seen <= hrst_sync[2];
    end
  end

  // Latched so the reset vector wins even if the pin pulse is short
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reset_req_q <= 1'b0;
    end else if (hrst_seen) begin
      reset_req_q <= 1'b1;
    end else if (long_call_accept_in && irq_offer_out && irq_vector_out == RESET_VECTOR) begin
      reset_req_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Offer register
  // ------------------------------------------------------------
  // One register stage keeps request-to-offer at one clock, well inside the latency window
  logic             next_offer;
  logic [VEC_W-1:0] next_vector;
  logic [IDX_W-1:0] next_source;
  logic             taking;

  assign taking = long_call_accept_in & irq_offer_out;

  always_comb begin
    next_offer  = 1'b0;
    next_vector = RESET_VECTOR;
    next_source = '0;
    // A taken offer always falls for one cycle, the reset vector too
    if (reset_req_q && !taking) begin
      next_offer = 1'b1;
    end else if (win_allowed && !taking) begin
      next_offer  = 1'b1;
      next_source = win_src;
      next_vector = VECTOR_BASE + VEC_W'({win_src, 3'b000});
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_offer_out  <= 1'b0;
      irq_vector_out <= RESET_VECTOR;
      irq_source_out <= '0;
    end else begin
      irq_offer_out  <= next_offer;
      irq_vector_out <= next_vector;
      irq_source_out <= next_source;
    end
  end

  // Acknowledge clears the served source's pending flag in the peripheral
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_ack_out <= '0;
    end else begin
      irq_ack_out <= '0;
      if (taking && irq_vector_out != RESET_VECTOR) begin
        irq_ack_out[irq_source_out] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Global enable
  // ------------------------------------------------------------
  // Vector entry beats a software set in the same cycle, so entry is never reopened early
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      global_irq_enable <= 1'b0;
    end else if (taking || hrst_seen) begin
      global_irq_enable <= 1'b0;
    end else if (return_from_irq_in || global_irq_enable_set_in) begin
      global_irq_enable <= 1'b1;
    end else if (global_irq_enable_clr_in) begin
      global_irq_enable <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      global_irq_enable_out <= 1'b0;
    end else begin
      global_irq_enable_out <= global_irq_enable;
    end
  end

  // ------------------------------------------------------------
  // In-service levels for nesting
  // ------------------------------------------------------------
  logic [1:0] offer_level;
  assign offer_level = src_level[irq_source_out];

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      level_in_service <= 4'h0;
    end else if (hrst_seen || (taking && irq_vector_out == RESET_VECTOR)) begin
      level_in_service <= 4'h0;
    end else if (taking) begin
      level_in_service[offer_level] <= 1'b1;
    end else if (return_from_irq_in) begin
      level_in_service[svc_top] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      active_level_out <= 2'h0;
      in_service_out   <= 1'b0;
    end else begin
      active_level_out <= svc_top;
      in_service_out   <= (level_in_service != 4'h0);
    end
  end

endmodule // gpvi_controller

// ### testbench/gpvi_assertions.sv
// Purpose: Port checks of the interrupt controller
// Assumes: One clock, async active-low reset
// Notes:   A nonzero vector marks a maskable offer
`timescale 1ns/1ns
module gpvi_assertions (
  input wire logic        ref_clk_in,
  input wire logic        reset_n_in,
  input wire logic        long_call_accept_in,
  input wire logic        return_from_irq_in,
  input wire logic        global_irq_enable_set_in,
  input wire logic        global_irq_enable_clr_in,
  input wire logic        irq_offer_out,
  input wire logic [15:0] irq_vector_out,
  input wire logic [4:0]  irq_source_out,
  input wire logic [22:0] irq_ack_out,
  input wire logic        global_irq_enable_out,
  input wire logic        in_service_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_take; irq_offer_out && long_call_accept_in; endsequence
  sequence s_mask; irq_offer_out && irq_vector_out != 16'h0000; endsequence
  chk_vector_map: assert property (s_mask |->
    irq_vector_out == 16'({irq_source_out, 3'b000}) + 16'h0003) else $error("bad vector");
  chk_source_range: assert property (s_mask |-> irq_source_out <= 5'h16)
    else $error("unused slot offered");
  chk_ack_take: assert property (s_take and s_mask |=>
    irq_ack_out == (23'h000001 << $past(irq_source_out))) else $error("bad ack");
  chk_offer_drops: assert property (s_take |=> !irq_offer_out)
    else $error("offer kept after take");
  chk_ack_pulse: assert property (irq_ack_out != 23'h0 |=> irq_ack_out == 23'h0)
    else $error("ack longer than one cycle");
  chk_ge_blocks: assert property (!global_irq_enable_out ##1 !global_irq_enable_out
    |-> !irq_offer_out || irq_vector_out == 16'h0000) else $error("offer while disabled");
  chk_ge_clears: assert property ((s_take and s_mask) ##1
    (!return_from_irq_in && !global_irq_enable_set_in) |=> !global_irq_enable_out
    && in_service_out) else $error("enable kept on entry");
  chk_return_sets: assert property (return_from_irq_in && !global_irq_enable_clr_in
    && !(irq_offer_out && long_call_accept_in) |-> ##2 global_irq_enable_out)
    else $error("enable not restored");
endmodule // gpvi_assertions
bind gpvi_controller gpvi_assertions i_gpvi_assertions (.ref_clk_in, .reset_n_in,
  .long_call_accept_in, .return_from_irq_in, .global_irq_enable_set_in,
  .global_irq_enable_clr_in, .irq_offer_out, .irq_vector_out, .irq_source_out,
  .irq_ack_out, .global_irq_enable_out, .in_service_out);

// ### testbench/gpvi_cpu_model.sv
// Purpose: CPU side that long-calls offered vectors
// Assumes: Accept is sampled with the offer on one edge
// Notes:   wait_in sets offer cycles before the take
`timescale 1ns/1ns
module gpvi_cpu_model (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       offer_in,
  input  wire logic [3:0] wait_in,
  output logic            accept_out
);
  logic [3:0] cnt;
  // Pulse only, a held accept would take a later offer unasked
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt        <= 4'h0;
      accept_out <= 1'b0;
    end else begin
      accept_out <= offer_in && !accept_out && cnt >= wait_in;
      cnt        <= (offer_in && !accept_out) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // gpvi_cpu_model

// ### testbench/test_gpvi_controller.sv
// Purpose: Self-checking bench of the interrupt controller
// Assumes: Inputs change on the falling edge
// Notes:   Expected takes are queued, checked at each take
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED at %0t: mismatch", $time); end end
module test_gpvi_controller;
  import gpvi_pkg::*;
  logic ref_clk_in = 0, reset_n_in = 0, hrst = 0, set = 0, clr = 0, ret = 0;
  logic accept, offer, ge, in_srv;
  logic [22:0] req = '0, ack;
  logic [15:0] vec;
  logic [4:0]  src;
  logic [1:0]  lvl_out;
  logic [3:0]  wt = 4'h0;
  logic [31:0] rnd = 32'h94d058d7;
  gpvi_cfg_s   cfg = {6'h3f, 6'h3f, 6'h3f, 5'h1f, 12'h000};
  logic [20:0] exp_q[$];
  int mismatches = 0, n_compared = 0, n_served = 0, a, b, w;
  gpvi_controller i_gpvi_controller (.ref_clk_in, .reset_n_in, .irq_request_in(req),
    .hardware_reset_pin_in(hrst), .cfg_in(cfg), .global_irq_enable_set_in(set),
    .global_irq_enable_clr_in(clr), .long_call_accept_in(accept), .return_from_irq_in(ret),
    .irq_offer_out(offer), .irq_vector_out(vec), .irq_source_out(src), .irq_ack_out(ack),
    .global_irq_enable_out(ge), .active_level_out(lvl_out), .in_service_out(in_srv));
  gpvi_cpu_model i_gpvi_cpu_model (.ref_clk_in, .reset_n_in, .offer_in(offer),
    .wait_in(wt), .accept_out(accept));
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [1:0] lv(int s);
    return {cfg.priority_high_bits[s % 6], cfg.priority_low_bits[s % 6]};
  endfunction
  function automatic logic [20:0] ex(int s);
    return {5'(s), 16'h0003 + 16'(s * 8)};
  endfunction
  task automatic final_report();
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(int n); repeat (n) @(negedge ref_clk_in); endtask
  task automatic pulse(ref logic s); s = 1'b1; tick(1); s = 1'b0; endtask
  task automatic quiet(); repeat (10) begin tick(1); `CHK(offer, 1'b0) end endtask
  task automatic drain(int n, bit rt);
    int i, t;
    repeat (n) begin
      t = n_served + 1;
      for (i = 0; i < 60 && n_served < t; i++) tick(1);
      if (i == 60) `CHK(1'b0, 1'b1)
      tick(3);
      `CHK(ge, 1'b0)
      if (rt) pulse(ret);
    end
  endtask
  initial forever #5 ref_clk_in = ~ref_clk_in;
  initial begin #400000; mismatches++; final_report(); end
  // Sources drop a request once it is acknowledged
  always @(negedge ref_clk_in) if (ack !== 23'h0) req <= req & ~ack;
  always @(posedge ref_clk_in) if (offer === 1'b1 && accept === 1'b1) begin
    if (exp_q.size() == 0) `CHK(1'b0, 1'b1)
    else `CHK({(vec == 16'h0000) ? 5'h00 : src, vec}, exp_q.pop_front())
    n_served++;
  end
  initial begin
    repeat (20) @(posedge ref_clk_in);
    tick(1); reset_n_in = 1; tick(2); pulse(set);
    for (int s = 0; s < 23; s++) begin
      rnd = xs(rnd); wt = rnd[3:0]; cfg[11:0] = rnd[15:4];
      exp_q.push_back(ex(s)); req[s] = 1'b1; drain(1, 1);
    end
    repeat (20) begin
      rnd = xs(rnd); a = rnd[7:0] % 23; b = rnd[15:8] % 23; cfg[11:0] = rnd[27:16];
      if (a == b) b = (a + 1) % 23;
      w = (lv(a) > lv(b) || (lv(a) == lv(b) && a < b)) ? a : b;
      exp_q.push_back(ex(w)); exp_q.push_back(ex(a + b - w));
      req[a] = 1'b1; req[b] = 1'b1; drain(2, 1);
    end
    cfg.enable_reg_b = 6'h3e; req[6] = 1'b1; quiet();
    pulse(clr); cfg.enable_reg_b = 6'h3f; quiet();
    `CHK(ge, 1'b0)
    exp_q.push_back(ex(6)); pulse(set); drain(1, 1);
    pulse(clr); req[0] = 1'b1; exp_q.push_back(21'h0);
    hrst = 1'b1; tick(3); hrst = 1'b0; drain(1, 0);
    exp_q.push_back(ex(0)); pulse(set); drain(1, 1);
    cfg[11:0] = 12'h083; exp_q.push_back(ex(0)); req[0] = 1'b1; drain(1, 0);
    exp_q.push_back(ex(1)); pulse(set); req[1] = 1'b1; drain(1, 0);
    req[6] = 1'b1; pulse(set); quiet();
    `CHK(lvl_out, 2'h3)
    `CHK(in_srv, 1'b1)
    exp_q.push_back(ex(6)); pulse(ret); quiet(); pulse(ret); drain(1, 1);
    final_report();
  end
endmodule // test_gpvi_controller
